// ### design/ocfs_pkg.sv
// package: register map, reset values, source codes and carriers for output clock selection
package ocfs_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // register offsets on the parallel register port
   localparam logic [7:0] ADDR_SEL_3_4 = 8'h61;
   localparam logic [7:0] ADDR_SEL_5_6 = 8'h62;
   localparam logic [7:0] ADDR_SEL_7_11 = 8'h63;
   localparam logic [7:0] ADDR_AUX_CFG = 8'h64;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h65;

   // values after reset
   localparam logic [7:0] RST_SEL_3_4 = 8'h00;
   localparam logic [7:0] RST_SEL_5_6 = 8'h8A;
   localparam logic [7:0] RST_SEL_7_11 = 8'h00;
   localparam logic [7:0] RST_AUX_CFG = 8'h01;
   localparam logic [7:0] RST_MAIN_CFG = 8'h01;

   // implemented bits; the rest read as zero
   localparam logic [7:0] MASK_AUX_CFG = 8'h77;
   localparam logic [7:0] MASK_MAIN_CFG = 8'hF7;

   // field positions
   localparam int POS_SYNC2K_EN = 7;
   localparam int POS_SYNC8K_EN = 6;
   localparam int POS_LINE_EN = 5;
   localparam int POS_COMP_EN = 4;
   localparam int POS_AUTO_SQUELCH = 6;
   localparam int POS_DUTY_SEL = 5;
   localparam int POS_STD_SEL = 4;
   localparam int POS_PHASE_MEAS = 7;
   localparam int POS_APLL_SRC = 6;
   localparam int POS_RATE_LO = 4;

   // divide ratios of the two analog pll tap chains
   localparam int MAIN_DIV_NUM = 7;
   localparam int AUX_DIV_NUM = 5;
   localparam int MAIN_RATIO [MAIN_DIV_NUM] = '{2, 4, 6, 8, 12, 16, 48};
   localparam int AUX_RATIO [AUX_DIV_NUM] = '{4, 8, 16, 48, 64};
   localparam int OUT_NUM = 5;
   localparam int GATED_NUM = 4;

   // selectable clock sources, in the bit order of the source vector
   typedef enum logic [4:0] {
      SRC_OFF, SRC_2K, SRC_8K, SRC_SYN1, SRC_SYN2, SRC_M1,
      SRC_M2, SRC_M4, SRC_M6, SRC_M8, SRC_M12, SRC_M16, SRC_M48,
      SRC_A4, SRC_A8, SRC_A16, SRC_A48, SRC_A64
   } ocfs_src_type;
   localparam int SRC_NUM = 18;

   // aux digital pll modes
   typedef enum logic [2:0] {
      AUX_SQUELCH, AUX_OC3, AUX_12E1, AUX_16E1, AUX_24DS1, AUX_16DS1, AUX_E3, AUX_DS3
   } ocfs_aux_mode_type;

   // raw clock waveforms from the clock generators, sampled on clk
   typedef struct packed {
      logic mainApll;
      logic auxApll;
      logic synth1;
      logic synth2;
      logic sync2k;
      logic sync8k;
      logic composite;
      logic lineTiming;
   } ocfs_src_clk_type;

   // controls handed to the pll blocks
   typedef struct packed {
      logic auxDpllRun;
      ocfs_aux_mode_type auxDpllMode;
      logic phaseMeasure;
      logic auxApllFromMain;
      logic [1:0] mainToAuxRate;
      logic [2:0] mainDpllMode;
      logic compositeDutySelect;
      logic lineTimingStandardSelect;
   } ocfs_pll_ctrl_type;
endpackage : ocfs_pkg

// ### design/ocfs_clk_div.sv
// even-ratio clock divider following the rising edges of a sampled source
`timescale 1ns/10ps
module ocfs_clk_div #(
   parameter int RATIO = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // source and divided clock
   input wire logic srcClk,
   output logic divClk
);
   localparam int HALF = RATIO / 2;
   localparam int CW = $clog2(HALF + 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);

   logic srcPrev_ff;
   logic [CW-1:0] cnt_ff;
   logic divClk_ff;

   ////////////////////////////////////////////////////////////////////////////
   // edge memory of the source
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcPrev_ff <= 1'b0;
      end else if (clkEn) begin
         srcPrev_ff <= srcClk;
      end
   end

   // toggle every half ratio of source rising edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         divClk_ff <= 1'b0;
      end else if (clkEn && srcClk && !srcPrev_ff) begin
         if (cnt_ff == HALF_LAST) begin
            cnt_ff <= '0;
            divClk_ff <= !divClk_ff;
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end

   assign divClk = divClk_ff;
endmodule : ocfs_clk_div

// ### design/ocfs_output_select.sv
// output clock selection: register file, source dividers, glitch-free output muxes
`timescale 1ns/10ps
module ocfs_output_select (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   // clock sources and status
   input ocfs_pkg::ocfs_src_clk_type srcClk,
   input wire logic auxInputsFailed,
   // clock outputs
   output logic [ocfs_pkg::OUT_NUM-1:0] clockOut3To7,
   output logic clockOut8,
   output logic clockOut9,
   output logic clockOut10,
   output logic clockOut11,
   // pll controls
   output ocfs_pkg::ocfs_pll_ctrl_type pllCtrl
);
   logic [7:0] sel34_ff;
   logic [7:0] sel56_ff;
   logic [7:0] sel711_ff;
   logic [7:0] auxCfg_ff;
   logic [7:0] mainCfg_ff;
   logic [7:0] rdData_ff;
   logic [ocfs_pkg::MAIN_DIV_NUM-1:0] mainDiv;
   logic [ocfs_pkg::AUX_DIV_NUM-1:0] auxDiv;
   logic [ocfs_pkg::SRC_NUM-1:0] srcVec;
   logic [3:0] selCode [ocfs_pkg::OUT_NUM];
   logic [ocfs_pkg::GATED_NUM-1:0] gatedSrc;
   logic [ocfs_pkg::GATED_NUM-1:0] gatedWant;
   logic [ocfs_pkg::GATED_NUM-1:0] gateEn_ff;
   logic [ocfs_pkg::GATED_NUM-1:0] gatedOut_ff;
   logic squelchAux;

   ////////////////////////////////////////////////////////////////////////////
   // selector code to source, per output number 3..7
   // outputs 5, 6 and 7 shift the tap codes, so the output number steers the decode
   function automatic ocfs_pkg::ocfs_src_type srcOf(input int outNum, input logic [3:0] code);
      ocfs_pkg::ocfs_src_type s;
      s = ocfs_pkg::SRC_OFF;
      unique case (code)
         4'h0: s = ocfs_pkg::SRC_OFF;
         4'h1: s = ocfs_pkg::SRC_2K;
         4'h2: s = ocfs_pkg::SRC_8K;
         4'h3: s = (outNum == 6) ? ocfs_pkg::SRC_M2 : ocfs_pkg::SRC_SYN2;
         4'h4: s = (outNum == 7) ? ocfs_pkg::SRC_M48 : ocfs_pkg::SRC_SYN1;
         4'h5: s = (outNum == 6) ? ocfs_pkg::SRC_M1 :
                   (outNum == 7) ? ocfs_pkg::SRC_M16 : ocfs_pkg::SRC_M48;
         4'h6: s = (outNum == 7) ? ocfs_pkg::SRC_M12 : ocfs_pkg::SRC_M16;
         4'h7: s = (outNum == 7) ? ocfs_pkg::SRC_M8 : ocfs_pkg::SRC_M12;
         4'h8: s = (outNum == 7) ? ocfs_pkg::SRC_M6 : ocfs_pkg::SRC_M8;
         4'h9: s = (outNum == 7) ? ocfs_pkg::SRC_M4 : ocfs_pkg::SRC_M6;
         4'hA: s = (outNum == 7) ? ocfs_pkg::SRC_M2 : ocfs_pkg::SRC_M4;
         4'hB: s = (outNum == 5) ? ocfs_pkg::SRC_M2 : ocfs_pkg::SRC_A64;
         4'hC: s = ocfs_pkg::SRC_A48;
         4'hD: s = ocfs_pkg::SRC_A16;
         4'hE: s = ocfs_pkg::SRC_A8;
         4'hF: s = ocfs_pkg::SRC_A4;
      endcase
      return s;
   endfunction : srcOf

   ////////////////////////////////////////////////////////////////////////////
   // register writes, unused bits kept at zero
   // writes to unmapped addresses fall through and change nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel34_ff <= ocfs_pkg::RST_SEL_3_4;
         sel56_ff <= ocfs_pkg::RST_SEL_5_6;
         sel711_ff <= ocfs_pkg::RST_SEL_7_11;
         auxCfg_ff <= ocfs_pkg::RST_AUX_CFG;
         mainCfg_ff <= ocfs_pkg::RST_MAIN_CFG;
      end else if (clkEn && regWrEn) begin
         unique case (regAddr)
            ocfs_pkg::ADDR_SEL_3_4: sel34_ff <= regWrData;
            ocfs_pkg::ADDR_SEL_5_6: sel56_ff <= regWrData;
            ocfs_pkg::ADDR_SEL_7_11: sel711_ff <= regWrData;
            ocfs_pkg::ADDR_AUX_CFG: auxCfg_ff <= regWrData & ocfs_pkg::MASK_AUX_CFG;
            ocfs_pkg::ADDR_MAIN_CFG: mainCfg_ff <= regWrData & ocfs_pkg::MASK_MAIN_CFG;
            default: ;
         endcase
      end
   end

   // registered read data, unmapped reads return zero
   // a read in the cycle of a write to the same place returns the old value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_ff <= 8'h00;
      end else if (clkEn && regRdEn) begin
         unique case (regAddr)
            ocfs_pkg::ADDR_SEL_3_4: rdData_ff <= sel34_ff;
            ocfs_pkg::ADDR_SEL_5_6: rdData_ff <= sel56_ff;
            ocfs_pkg::ADDR_SEL_7_11: rdData_ff <= sel711_ff;
            ocfs_pkg::ADDR_AUX_CFG: rdData_ff <= auxCfg_ff;
            ocfs_pkg::ADDR_MAIN_CFG: rdData_ff <= mainCfg_ff;
            default: rdData_ff <= 8'h00;
         endcase
      end
   end
   assign regRdData = rdData_ff;

   ////////////////////////////////////////////////////////////////////////////
   // divider chains on both analog pll outputs
   for (genvar i = 0; i < ocfs_pkg::MAIN_DIV_NUM; i++) begin : g_mainDiv
      ocfs_clk_div #(.RATIO(ocfs_pkg::MAIN_RATIO[i])) u_div (
         .clk(clk),
         .rst_n(rst_n),
         .clkEn(clkEn),
         .srcClk(srcClk.mainApll),
         .divClk(mainDiv[i])
      );
   end
   for (genvar i = 0; i < ocfs_pkg::AUX_DIV_NUM; i++) begin : g_auxDiv
      ocfs_clk_div #(.RATIO(ocfs_pkg::AUX_RATIO[i])) u_div (
         .clk(clk),
         .rst_n(rst_n),
         .clkEn(clkEn),
         .srcClk(srcClk.auxApll),
         .divClk(auxDiv[i])
      );
   end

   // source vector in enum order, bit 0 is the static-low off source
   // every tap but M1 comes from a flop on clk; M1 and the other direct sources are sampled on clk, so the muxes below see settled levels
   assign srcVec = {auxDiv[4], auxDiv[3], auxDiv[2], auxDiv[1], auxDiv[0],
                    mainDiv[6], mainDiv[5], mainDiv[4], mainDiv[3], mainDiv[2],
                    mainDiv[1], mainDiv[0], srcClk.mainApll, srcClk.synth2,
                    srcClk.synth1, srcClk.sync8k, srcClk.sync2k, 1'b0};

   assign selCode[0] = sel34_ff[3:0];
   assign selCode[1] = sel34_ff[7:4];
   assign selCode[2] = sel56_ff[3:0];
   assign selCode[3] = sel56_ff[7:4];
   assign selCode[4] = sel711_ff[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // glitch-free muxes for outputs 3..7: switch only while both old and new are low
   // a high phase already begun is never cut short by a new code
   for (genvar o = 0; o < ocfs_pkg::OUT_NUM; o++) begin : g_outMux
      ocfs_pkg::ocfs_src_type cur_ff;
      ocfs_pkg::ocfs_src_type want;
      logic out_ff;
      assign want = srcOf(o + 3, selCode[o]);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cur_ff <= ocfs_pkg::SRC_OFF;
            out_ff <= 1'b0;
         end else if (clkEn) begin
            if (cur_ff == want || out_ff) begin
               out_ff <= srcVec[cur_ff]; // finish the running high phase
            end else if (!srcVec[want]) begin
               cur_ff <= want;
            end
         end
      end
      assign clockOut3To7[o] = out_ff;
   end

   ////////////////////////////////////////////////////////////////////////////
   // enables of outputs 8..11 with aux auto-squelch
   assign squelchAux = auxCfg_ff[ocfs_pkg::POS_AUTO_SQUELCH] && auxInputsFailed;
   assign gatedSrc = {srcClk.sync2k, srcClk.sync8k, srcClk.lineTiming, srcClk.composite};
   assign gatedWant = {sel711_ff[ocfs_pkg::POS_SYNC2K_EN],
                       sel711_ff[ocfs_pkg::POS_SYNC8K_EN],
                       sel711_ff[ocfs_pkg::POS_LINE_EN] && !squelchAux,
                       sel711_ff[ocfs_pkg::POS_COMP_EN] && !squelchAux};

   // gate changes only while source and output are low
   // squelch waits for a low phase as well, so outputs 8 and 9 never show a runt
   for (genvar g = 0; g < ocfs_pkg::GATED_NUM; g++) begin : g_gate
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            gateEn_ff[g] <= 1'b0;
            gatedOut_ff[g] <= 1'b0;
         end else if (clkEn) begin
            if (!gatedSrc[g] && !gatedOut_ff[g]) begin
               gateEn_ff[g] <= gatedWant[g];
            end
            gatedOut_ff[g] <= gatedSrc[g] && (gateEn_ff[g] || gatedOut_ff[g]);
         end
      end
   end
   assign clockOut8 = gatedOut_ff[0];
   assign clockOut9 = gatedOut_ff[1];
   assign clockOut10 = gatedOut_ff[2];
   assign clockOut11 = gatedOut_ff[3];

   ////////////////////////////////////////////////////////////////////////////
   // pll controls straight from the configuration registers
   // plain decodes of register bits, so they follow a write one cycle later
   always_comb begin
      pllCtrl.auxDpllMode = ocfs_pkg::ocfs_aux_mode_type'(auxCfg_ff[2:0]);
      pllCtrl.phaseMeasure = mainCfg_ff[ocfs_pkg::POS_PHASE_MEAS];
      pllCtrl.auxDpllRun = (auxCfg_ff[2:0] != ocfs_pkg::AUX_SQUELCH) &&
                           !mainCfg_ff[ocfs_pkg::POS_PHASE_MEAS];
      pllCtrl.auxApllFromMain = mainCfg_ff[ocfs_pkg::POS_APLL_SRC];
      pllCtrl.mainToAuxRate = mainCfg_ff[ocfs_pkg::POS_RATE_LO +: 2];
      pllCtrl.mainDpllMode = mainCfg_ff[2:0];
      pllCtrl.compositeDutySelect = auxCfg_ff[ocfs_pkg::POS_DUTY_SEL];
      pllCtrl.lineTimingStandardSelect = auxCfg_ff[ocfs_pkg::POS_STD_SEL];
   end
endmodule : ocfs_output_select

// ### sim/ocfs_output_select_chk.sv
// checker: register decodes and output clock relations of the output selector
`timescale 1ns/10ps
module ocfs_output_select_chk (
   // clock, reset, register port
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   // sources, status, outputs
   input ocfs_pkg::ocfs_src_clk_type srcClk,
   input wire logic auxInputsFailed,
   input wire logic [ocfs_pkg::OUT_NUM-1:0] clockOut3To7,
   input wire logic clockOut8,
   input wire logic clockOut9,
   input wire logic clockOut10,
   input wire logic clockOut11,
   input ocfs_pkg::ocfs_pll_ctrl_type pllCtrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   // taken writes to the two pll registers
   sequence s_wr64;
      clkEn && regWrEn && regAddr == ocfs_pkg::ADDR_AUX_CFG;
   endsequence
   sequence s_wr65;
      clkEn && regWrEn && regAddr == ocfs_pkg::ADDR_MAIN_CFG;
   endsequence
   property p_mode;
      s_wr64 |=> pllCtrl.auxDpllMode == $past(regWrData[2:0]);
   endproperty
   a_mode: assert property (p_mode) else $error("aux mode not stored");
   property p_run;
      pllCtrl.auxDpllRun == (pllCtrl.auxDpllMode != 3'h0 && !pllCtrl.phaseMeasure);
   endproperty
   a_run: assert property (p_run) else $error("aux run decode wrong");
   property p_meas;
      s_wr65 |=> pllCtrl.phaseMeasure == $past(regWrData[7]);
   endproperty
   a_meas: assert property (p_meas) else $error("phase measure not stored");
   property p_src;
      s_wr65 |=> pllCtrl.auxApllFromMain == $past(regWrData[6]);
   endproperty
   a_src: assert property (p_src) else $error("aux apll source not stored");
   property p_rate;
      s_wr65 |=> pllCtrl.mainToAuxRate == $past(regWrData[5:4]);
   endproperty
   a_rate: assert property (p_rate) else $error("aux apll rate not stored");
   // gated outputs 9, 10 and 11 rise only after their source was high
   property p_rise9;
      $rose(clockOut9) |-> $past(srcClk.lineTiming);
   endproperty
   a_rise9: assert property (p_rise9) else $error("output 9 rose without source");
   property p_rise10;
      $rose(clockOut10) |-> $past(srcClk.sync8k);
   endproperty
   a_rise10: assert property (p_rise10) else $error("output 10 rose without source");
   property p_rise11;
      $rose(clockOut11) |-> $past(srcClk.sync2k);
   endproperty
   a_rise11: assert property (p_rise11) else $error("output 11 rose without source");
   property p_freeze;
      !clkEn |=> $stable(clockOut3To7) && $stable(clockOut8) && $stable(regRdData);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule : ocfs_output_select_chk

bind ocfs_output_select ocfs_output_select_chk u_ocfs_output_select_chk (.clk, .rst_n,
   .clkEn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .srcClk, .auxInputsFailed,
   .clockOut3To7, .clockOut8, .clockOut9, .clockOut10, .clockOut11, .pllCtrl);

// ### sim/tb.sv
// testbench: register access and output clock selection scenarios
`timescale 1ns/10ps
module tb;
   logic clk = 1'h0, rst_n = 1'h0, clkEn = 1'h1, regWrEn = 1'h0, regRdEn = 1'h0;
   logic auxInputsFailed = 1'h0, clockOut8, clockOut9, clockOut10, clockOut11;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
   logic [7:0] sh [3] = '{8'h00, 8'h8A, 8'h00};
   logic [4:0] clockOut3To7;
   logic [8:0] outs;
   logic [15:0] cyc = 16'h0000;
   logic [3:0] v;
   ocfs_pkg::ocfs_src_clk_type srcClk = '0;
   ocfs_pkg::ocfs_pll_ctrl_type pllCtrl;
   int err_count = 0, n_checks = 0;
   assign outs = {clockOut11, clockOut10, clockOut9, clockOut8, clockOut3To7};
   always #5 clk = ~clk;
   // test sources of periods 4 to 128 clocks, all slower than half the clock
   always @(posedge clk) begin
      #1 cyc = cyc + 16'h0001;
      srcClk = {cyc[1], cyc[2], cyc[6], cyc[5], cyc[4], cyc[3], cyc[2], cyc[3]};
   end
   ocfs_output_select u_ocfs_output_select (.clk, .rst_n, .clkEn, .regAddr, .regWrData,
      .regWrEn, .regRdEn, .regRdData, .srcClk, .auxInputsFailed, .clockOut3To7, .clockOut8,
      .clockOut9, .clockOut10, .clockOut11, .pllCtrl);
   ////////////////////////////////////////////////////////////
   task automatic results;
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task automatic chk(input bit ok, input string m);
      n_checks++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask : chk
   // register port cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 regAddr = a;
      regWrData = d;
      regWrEn = 1'h1;
      @(posedge clk);
      #1 regWrEn = 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 regAddr = a;
      regRdEn = 1'h1;
      @(posedge clk);
      #1 regRdEn = 1'h0;
      chk(regRdData === e, "read data");
   endtask : rd
   // set one output selector, keeping the other nibble
   task automatic sel(input int o, input logic [3:0] c);
      int i;
      i = (o - 3) / 2;
      if (o % 2)
         sh[i][3:0] = c;
      else
         sh[i][7:4] = c;
      wr(ocfs_pkg::ADDR_SEL_3_4 + 8'(i), sh[i]);
   endtask : sel
   // skip two rising edges, then time one full period
   task automatic per(input int o, input int e);
      int k, n, t;
      logic p;
      k = 0;
      n = 0;
      t = 0;
      p = outs[o - 3];
      while (k < 3 && t < 3000) begin
         @(posedge clk);
         #1 t++;
         if (k == 2)
            n++;
         if (outs[o - 3] === 1'h1 && p === 1'h0)
            k++;
         p = outs[o - 3];
      end
      chk(k == 3 && n == e, "output period");
      if (k < 3)
         results();
   endtask : per
   // output must stay low once the change has settled
   task automatic quiet(input int o);
      logic h;
      h = 1'h0;
      repeat (300) @(posedge clk);
      repeat (600) begin
         @(posedge clk);
         #1 h = h | outs[o - 3];
      end
      chk(h === 1'h0, "output not static");
   endtask : quiet
   // expected period in clocks for output o and selector code c
   function automatic int ep(input int o, input int c);
      int m [7] = '{48, 16, 12, 8, 6, 4, 2};
      int a [5] = '{64, 48, 16, 8, 4};
      int b [4] = '{48, 16, 8, 4};
      if (c == 1)
         return 32;
      if (c == 2)
         return 16;
      if (c == 3)
         return (o == 6) ? 8 : 64;
      if (c == 4)
         return 128;
      if (o == 5)
         return (c < 12) ? 4 * m[c - 5] : 8 * b[c - 12];
      return (c < 11) ? 4 * m[c - 5] : 8 * a[c - 11];
   endfunction : ep
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'h1;
      // reset values, masked bits, unmapped place, frozen write
      rd(8'h61, 8'h00);
      rd(8'h62, 8'h8A);
      rd(8'h63, 8'h00);
      rd(8'h64, 8'h01);
      rd(8'h65, 8'h01);
      wr(8'h64, 8'hFF);
      #10 chk(pllCtrl.compositeDutySelect === 1'h1, "duty select");
      chk(pllCtrl.lineTimingStandardSelect === 1'h1, "standard select");
      rd(8'h64, 8'h77);
      wr(8'h70, 8'h55);
      rd(8'h70, 8'h00);
      clkEn = 1'h0;
      wr(8'h61, 8'h11);
      clkEn = 1'h1;
      rd(8'h61, 8'h00);
      // aux digital pll modes, phase measure, aux analog pll feed
      for (int m = 0; m < 8; m++) begin
         wr(8'h64, 8'(m));
         #10 chk(pllCtrl.auxDpllMode === 3'(m) && pllCtrl.auxDpllRun === (m != 0), "mode");
      end
      wr(8'h65, 8'h81);
      #10 chk(pllCtrl.phaseMeasure === 1'h1 && pllCtrl.auxDpllRun === 1'h0, "measure");
      for (v = 4'h0; v < 4'h8; v++) begin
         wr(8'h65, {1'h0, v[2:0], 4'h1});
         #10 chk(pllCtrl.auxApllFromMain === v[2], "feed source");
         chk(pllCtrl.mainToAuxRate === v[1:0], "feed rate");
         chk(pllCtrl.mainDpllMode === 3'h1, "main mode");
      end
      // aux digital pll running again once mode 1 is written with phase measure off
      wr(8'h64, 8'h01);
      #10 chk(pllCtrl.auxDpllRun === 1'h1, "aux running");
      // selector codes 1 to 15 on outputs 3 and 5
      for (int o = 3; o < 6; o += 2) begin
         for (int c = 1; c < 16; c++) begin
            sel(o, c[3:0]);
            per(o, ep(o, c));
         end
      end
      sel(6, 4'h3);
      per(6, 8);
      sel(4, 4'hF);
      per(4, 32);
      sel(7, 4'hB);
      per(7, 512);
      sel(7, 4'h3);
      per(7, 64);
      sel(3, 4'h0);
      quiet(3);
      // sync, line and composite enables, then squelch
      sh[2] = 8'hF3;
      wr(8'h63, sh[2]);
      per(8, 8);
      per(9, 16);
      per(10, 16);
      per(11, 32);
      auxInputsFailed = 1'h1;
      per(8, 8);
      wr(8'h64, 8'h41);
      quiet(8);
      quiet(9);
      per(10, 16);
      auxInputsFailed = 1'h0;
      per(9, 16);
      for (int e = 0; e < 4; e++) begin
         sh[2][4 + e] = 1'h0;
         wr(8'h63, sh[2]);
         quiet(8 + e);
      end
      // mid-run reset: outputs drop at once, registers back to reset values
      rst_n = 1'h0;
      #1 chk(outs === 9'h000 && regRdData === 8'h00, "reset outputs");
      repeat (2) @(posedge clk);
      #1 rst_n = 1'h1;
      rd(8'h62, 8'h8A);
      rd(8'h63, 8'h00);
      rd(8'h65, 8'h01);
      results();
   end
endmodule : tb
